/* rtl/chbp_device.sv */
// Device end: decodes host bus cycles into register strobes, spare gate, time mark.
// Assumes bus pins arrive asynchronously; the five control pins are synchronised on sys_clk, address and data are not.
`default_nettype none
module chbp_device
	import chbp_pkg::*;
#(
	parameter int MARK_COUNT = MARK_CYCLES
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// Host bus
	chbp_bus_if.dev                bus,
	// User register side
	output logic [ADDR_W-1:0]      regAddr,
	output logic [DATA_W-1:0]      regWrData,
	output logic                   regWrStb,
	output logic                   regRdStb,
	input  wire logic [DATA_W-1:0] regRdData
);
	typedef struct packed {
		logic [4:0]        s1;
		logic [4:0]        s2;
		logic [ADDR_W-1:0] addrLat;
		logic [DATA_W-1:0] wrData;
		logic              wrPend;
		logic              rdAct;
		logic [DATA_W-1:0] rdData;
		logic [ADDR_W-1:0] regAddr;
		logic              wrStb;
		logic              rdStb;
		logic              rdStbD;
		logic [31:0]       markCnt;
		logic              mark;
	} chbp_dev_state_t;

	chbp_dev_state_t st_r, st_nxt;
	logic style, ale, en, dir, wrdly, isRd, isWr, wrHold;

	////////////////////////////////////////////////////////////////////
	// Synchronised pin view (second stage only)
	assign style = st_r.s2[0];
	assign en    = st_r.s2[1];
	assign dir   = st_r.s2[2];
	assign ale   = st_r.s2[3];
	assign wrdly = st_r.s2[4];

	// Cycle decode per bus style
	always_comb begin
		if (style) begin
			isRd = en && dir;
			isWr = en && !dir;
		end else begin
			isRd = !en && dir;
			isWr = !dir && en;
		end
		// Delayed mode keeps the write pending while the latch strobe is high
		wrHold = wrdly ? (isWr || ale) : isWr;
	end

	////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = {bus.writeDelaySelect, bus.addrLatch, bus.dirOrWr, bus.enableOrRd, bus.busStyleSelect};
		st_nxt.s2 = st_r.s1;
		st_nxt.wrStb = 1'b0;
		st_nxt.rdStb = 1'b0;
		// Address sampled while latch strobe high
		if (ale)
			st_nxt.addrLat = bus.addr;
		if (isWr) begin
			st_nxt.wrData = bus.hostDataOut;
			st_nxt.wrPend = 1'b1;
		end
		// Write fires at the trailing edge of the (possibly stretched) write
		if (st_r.wrPend && !wrHold) begin
			st_nxt.wrPend  = 1'b0;
			st_nxt.wrStb   = 1'b1;
			st_nxt.regAddr = st_r.addrLat;
		end else if (isRd && !st_r.rdAct) begin
			st_nxt.rdStb   = 1'b1;
			st_nxt.regAddr = st_r.addrLat;
		end
		st_nxt.rdAct = isRd;
		// Register side answers one cycle after the read strobe, so take it then
		st_nxt.rdStbD = st_r.rdStb;
		if (st_r.rdStbD)
			st_nxt.rdData = regRdData;
		// One-second mark, single cycle
		st_nxt.mark = 1'b0;
		if (st_r.markCnt == 32'(MARK_COUNT - 1)) begin
			st_nxt.markCnt = '0;
			st_nxt.mark    = 1'b1;
		end else begin
			st_nxt.markCnt = st_r.markCnt + 32'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign regAddr          = st_r.regAddr;
	assign regWrData        = st_r.wrData;
	assign regWrStb         = st_r.wrStb;
	assign regRdStb         = st_r.rdStb;
	assign bus.devDataOut   = st_r.rdData;
	assign bus.devDataOe    = st_r.rdAct && isRd;
	assign bus.spareGateOut = ~(bus.spareGateInA & bus.spareGateInB);
	assign bus.timeMark     = st_r.mark;
endmodule : chbp_device
`default_nettype wire

/* rtl/chbp_pkg.sv */
// Constants shared by the correlator host bus port ends.
// Assumes one 50 MHz system clock and an active-low asynchronous reset.
`default_nettype none
package chbp_pkg;
	localparam int DATA_W        = 16;
	localparam int ADDR_W        = 8;
	localparam int CLK_HZ        = 50_000_000;
	localparam int MARK_PERIOD_S = 1;
	// Cycles between time marks, derived from clock rate
	localparam int MARK_CYCLES   = CLK_HZ * MARK_PERIOD_S;
	localparam logic [DATA_W-1:0] RD_RESET = 16'h0000;
endpackage : chbp_pkg
`default_nettype wire

/* rtl/chbp_bus_if.sv */
// Host bus wires between the host end and the device end.
// Assumes the testbench resolves the shared data bus from the enables.
`default_nettype none
interface chbp_bus_if;
	import chbp_pkg::*;
	logic              busStyleSelect;
	logic              writeDelaySelect;
	logic              addrLatch;
	logic [ADDR_W-1:0] addr;
	logic              enableOrRd;   // Enable (style 1) or read strobe, active low (style 0)
	logic              dirOrWr;      // Direction (style 1) or write strobe, active low (style 0)
	logic [DATA_W-1:0] hostDataOut;
	logic              hostDataOe;
	logic [DATA_W-1:0] devDataOut;
	logic              devDataOe;
	logic              spareGateInA;
	logic              spareGateInB;
	logic              spareGateOut;
	logic              timeMark;
	modport host (output busStyleSelect, writeDelaySelect, addrLatch, addr, enableOrRd, dirOrWr,
		hostDataOut, hostDataOe, spareGateInA, spareGateInB,
		input devDataOut, devDataOe, spareGateOut, timeMark);
	modport dev (input busStyleSelect, writeDelaySelect, addrLatch, addr, enableOrRd, dirOrWr,
		hostDataOut, hostDataOe, spareGateInA, spareGateInB,
		output devDataOut, devDataOe, spareGateOut, timeMark);
endinterface : chbp_bus_if
`default_nettype wire

/* rtl/chbp_host.sv */
// Host end: turns single-cycle user requests into host bus cycles.
// Assumes the device answers within the fixed hold time of each phase.
`default_nettype none
module chbp_host
	import chbp_pkg::*;
#(
	parameter int PHASE = 8
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              arst_n,
	// Static straps
	input  wire logic              styleSel,
	input  wire logic              wrDelaySel,
	// User command port
	input  wire logic [ADDR_W-1:0] cmdAddr,
	input  wire logic [DATA_W-1:0] cmdWrData,
	input  wire logic              cmdWr,
	input  wire logic              cmdRd,
	output logic [DATA_W-1:0]      rspRdData,
	output logic                   rspDone,
	output logic                   busy,
	// Host bus
	chbp_bus_if.host               bus
);
	typedef enum logic [3:0] {
		IDLE  = 4'b0001,
		LATCH = 4'b0010,
		XFER  = 4'b0100,
		DONE  = 4'b1000
	} chbp_hst_t;
	typedef struct packed {
		chbp_hst_t         fsm;
		logic [7:0]        cnt;
		logic              isRd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              done;
	} chbp_host_state_t;
	chbp_host_state_t st_r, st_nxt;

	////////////////////////////////////////////////////////////////////
	// Sequencer: latch address, hold strobes, sample read data
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		unique case (st_r.fsm)
			IDLE: begin
				if (cmdWr || cmdRd) begin
					st_nxt.isRd = cmdRd;
					st_nxt.addr = cmdAddr;
					st_nxt.data = cmdWrData;
					st_nxt.cnt  = '0;
					st_nxt.fsm  = LATCH;
				end
			end
			LATCH: begin
				st_nxt.cnt = st_r.cnt + 8'd1;
				if (st_r.cnt == 8'(PHASE - 1)) begin
					st_nxt.cnt = '0;
					st_nxt.fsm = XFER;
				end
			end
			XFER: begin
				st_nxt.cnt = st_r.cnt + 8'd1;
				if (st_r.cnt == 8'(PHASE - 1)) begin
					if (st_r.isRd)
						st_nxt.data = bus.devDataOut;
					st_nxt.fsm = DONE;
				end
			end
			DONE: begin
				st_nxt.done = 1'b1;
				st_nxt.fsm  = IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= '{fsm: IDLE, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pin drive per style; strobes idle inactive
	logic act;
	assign act = (st_r.fsm == XFER);
	assign bus.busStyleSelect   = styleSel;
	assign bus.writeDelaySelect = wrDelaySel;
	assign bus.addrLatch        = (st_r.fsm == LATCH);
	assign bus.addr             = st_r.addr;
	assign bus.enableOrRd       = styleSel ? act : !(act && st_r.isRd);
	assign bus.dirOrWr          = styleSel ? st_r.isRd : !(act && !st_r.isRd);
	assign bus.hostDataOut      = st_r.data;
	assign bus.hostDataOe       = act && !st_r.isRd;
	assign bus.spareGateInA     = 1'b1;
	assign bus.spareGateInB     = 1'b1;
	assign rspRdData            = st_r.data;
	assign rspDone              = st_r.done;
	assign busy                 = (st_r.fsm != IDLE);
endmodule : chbp_host
`default_nettype wire

/* verification/chbp_bus_chk.sv */
// Checker on the host bus wires between the two ends.
// Assumes one clock domain; sees interface signals only.
`default_nettype none
module chbp_bus_chk
	import chbp_pkg::*;
#(
	parameter int MARK_COUNT = MARK_CYCLES
) (
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              arst_n,
	// Bus wires
	input wire logic              busStyleSelect,
	input wire logic              addrLatch,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              enableOrRd,
	input wire logic              dirOrWr,
	input wire logic              hostDataOe,
	input wire logic              devDataOe,
	input wire logic              spareGateInA,
	input wire logic              spareGateInB,
	input wire logic              spareGateOut,
	input wire logic              timeMark
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	logic       rdDec;
	logic       act;
	logic [4:0] rdHist_r;
	int         markCnt_r;
	logic       markSeen_r;
	// Write decode is the same in both styles
	assign rdDec = busStyleSelect ? (enableOrRd && dirOrWr) : (!enableOrRd && dirOrWr);
	assign act = rdDec || (enableOrRd && !dirOrWr);
	////////////////////////////////////////////////////////////////
	// History spans the device's sync lag; mark spacing counter
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdHist_r <= '0;
			markCnt_r <= 0;
			markSeen_r <= 1'b0;
		end else begin
			rdHist_r <= {rdHist_r[3:0], rdDec};
			markCnt_r <= timeMark ? 0 : markCnt_r + 1;
			markSeen_r <= markSeen_r || timeMark;
		end
	end
	////////////////////////////////////////////////////////////////
	rd_drive_a: assert property (devDataOe |-> (rdHist_r != '0 || rdDec))
		else $error("data driven outside a read");
	no_fight_a: assert property (!(devDataOe && hostDataOe))
		else $error("both ends drive data");
	strobe_pair_a: assert property (!busStyleSelect |-> (enableOrRd || dirOrWr))
		else $error("both strobes low");
	enable_idle_a: assert property ((busStyleSelect && !enableOrRd)[*5] |-> !devDataOe)
		else $error("data driven with enable low");
	strobe_len_a: assert property ($rose(act) |-> act[*8] ##1 !act)
		else $error("strobe length wrong");
	latch_first_a: assert property ($rose(act) |-> $past(addrLatch))
		else $error("strobe without latched address");
	addr_hold_a: assert property (act && $past(act) |-> $stable(addr))
		else $error("address moved in a cycle");
	nand_a: assert property (spareGateOut == !(spareGateInA && spareGateInB))
		else $error("spare gate wrong");
	mark_len_a: assert property (timeMark |=> !timeMark)
		else $error("time mark too long");
	mark_period_a: assert property (timeMark && markSeen_r |-> markCnt_r == MARK_COUNT - 1)
		else $error("time mark spacing wrong");
	cover property ($rose(devDataOe));
	cover property ($rose(act) && !rdDec);
	cover property (timeMark && markSeen_r);
endmodule : chbp_bus_chk
`default_nettype wire

/* verification/correlator_host_bus_port_bench.sv */
// Bench joining host and device ends, with a register array model.
// Assumes PHASE 8 and a short time mark count.
`default_nettype none
module correlator_host_bus_port_bench import chbp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              sys_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic              styleSel = 1'b0;
	logic              wrDelaySel = 1'b0;
	logic              cmdWr = 1'b0;
	logic              cmdRd = 1'b0;
	logic [ADDR_W-1:0] cmdAddr = '0;
	logic [ADDR_W-1:0] regAddr;
	logic [DATA_W-1:0] cmdWrData = '0;
	logic [DATA_W-1:0] regRdData = '0;
	logic [DATA_W-1:0] rspRdData;
	logic [DATA_W-1:0] regWrData;
	logic              rspDone, busy, regWrStb, regRdStb;
	logic [DATA_W-1:0] mem [2**ADDR_W];
	int                nWr = 0;
	int                n_errors = 0;
	int                comparisons = 0;
	int                nMark = 0;
	// Short mark spacing keeps the run small
	localparam int     MARK_N = 100;
	chbp_bus_if bus ();
	chbp_host #(.PHASE(8)) u_chbp_host (.sys_clk(sys_clk), .arst_n(arst_n), .styleSel(styleSel),
		.wrDelaySel(wrDelaySel), .cmdAddr(cmdAddr), .cmdWrData(cmdWrData), .cmdWr(cmdWr),
		.cmdRd(cmdRd), .rspRdData(rspRdData), .rspDone(rspDone), .busy(busy), .bus(bus));
	chbp_device #(.MARK_COUNT(MARK_N)) u_chbp_device (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData));
	chbp_bus_chk #(.MARK_COUNT(MARK_N)) u_chbp_bus_chk (.sys_clk(sys_clk), .arst_n(arst_n),
		.busStyleSelect(bus.busStyleSelect), .addrLatch(bus.addrLatch), .addr(bus.addr),
		.enableOrRd(bus.enableOrRd), .dirOrWr(bus.dirOrWr), .hostDataOe(bus.hostDataOe),
		.devDataOe(bus.devDataOe), .spareGateInA(bus.spareGateInA), .spareGateInB(bus.spareGateInB),
		.spareGateOut(bus.spareGateOut), .timeMark(bus.timeMark));
	////////////////////////////////////////////////////////////////
	// Clock, and register array behind the device
	initial forever #10 sys_clk = ~sys_clk;
	initial foreach (mem[i]) mem[i] = '0;
	always @(posedge sys_clk) begin
		if (regWrStb) begin
			mem[regAddr] <= regWrData;
			nWr <= nWr + 1;
		end
		if (regRdStb) regRdData <= mem[regAddr];
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Dup holds a second request while busy; it must be ignored
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic dup);
		int i;
		@(posedge sys_clk);
		cmdAddr <= a;
		cmdWrData <= d;
		cmdWr <= wr;
		cmdRd <= !wr;
		@(posedge sys_clk);
		cmdAddr <= a + 8'h08;
		cmdWr <= dup;
		cmdRd <= 1'b0;
		@(posedge sys_clk);
		cmdWr <= 1'b0;
		for (i = 0; i < 60 && rspDone !== 1'b1; i++) @(negedge sys_clk);
		check({14'h0000, busy, rspDone}, 16'h0001);
	endtask : xfer
	task final_report;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	// Every style and write delay setting, each after a fresh reset
	initial begin
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		for (int c = 0; c < 4; c++) begin
			a = {c[2:0], 5'h03};
			d = {12'hA5C, c[3:0]};
			styleSel <= c[0];
			wrDelaySel <= c[1];
			arst_n <= 1'b0;
			repeat (16) @(posedge sys_clk);
			arst_n <= 1'b1;
			xfer(1'b1, a, d, 1'b1);
			xfer(1'b1, a + 8'h01, ~d, 1'b0);
			xfer(1'b0, a, '0, 1'b0);
			check(rspRdData, d);
			xfer(1'b0, a + 8'h01, '0, 1'b0);
			check(rspRdData, ~d);
			check(mem[a], d);
			check(mem[a + 8'h08], '0);
			check(16'(nWr), 16'(2 * c + 2));
			check({15'h0000, bus.spareGateOut}, 16'h0000);
			// Any window of two mark periods holds exactly two one-cycle marks
			nMark = 0;
			repeat (2 * MARK_N) begin
				@(negedge sys_clk);
				if (bus.timeMark === 1'b1) nMark++;
			end
			check(16'(nMark), 16'h0002);
			@(posedge sys_clk);
		end
		final_report;
	end
	// Watchdog against a hung handshake
	initial begin
		#400_000;
		n_errors++;
		final_report;
	end
endmodule : correlator_host_bus_port_bench
`default_nettype wire
